// ---- rtl/sac_pkg.sv ----
// Constants and types for the SAR converter serial control block.
// Overview of operation
// RULE_01: Host shifts control byte with select low.
// RULE_02: Track input only last 2.5 control clocks.
// RULE_03: Conversion starts on eighth falling clock edge.
// RULE_04: Twelve conversion clocks plus one shift clock.
// RULE_05: 24-clock format pads seven trailing zeros; the code pads four.
// RULE_06: Conversion clocked by link or oscillator.
// RULE_07: First one after select low starts byte.
// RULE_08: Bits 6 to 4 choose the channel.
// RULE_09: Bit 3 chooses unipolar or bipolar coding.
// RULE_10: Bit 2 chooses single-ended or differential input.
// RULE_11: Bits 1:0 choose power and clock mode.
// RULE_12: Internal mode converts without further link clocks.
// RULE_13: Done strobe low converting, high when ready; the code raises it only in internal clock mode.
// RULE_14: Next control byte accepted during result readout.
// RULE_15: Internal conversion continues with select high.
// RULE_16: Serial output released while select is high.
// RULE_17: 16-clock format overlaps readout and next byte.
// RULE_18: 13-clock format is the fastest supported.
// RULE_19: Host finishes conversion within 1.2 ms.
// RULE_20: Start bit wakes from software power-down.
// RULE_21: Shutdown pin low powers down, high wakes.
// RULE_22: Sample input rising, drive output falling, MSB first.
// RULE_23: Short formats shift result like 24-clock format.
package sac_pkg;
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned INT_OSC_KHZ = 3300;
  localparam logic [4:0] INT_OSC_CYCLES = 5'(CLK_KHZ / INT_OSC_KHZ);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TRACK_FROM_BIT = 4'h6;
  localparam logic [3:0] STEP_FIRST_BIT = 4'h1;
  localparam logic [3:0] STEP_LAST_BIT = 4'ha;
  localparam logic [3:0] STEP_LAST = 4'hc;
  localparam logic [3:0] RESULT_BITS = 4'ha;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [4:0] CTRL_RESET = INT_OSC_CYCLES;
  localparam int LNK_SCLK = 0;
  localparam int LNK_CS = 1;
  localparam int LNK_SDI = 2;
  localparam int LNK_HWPD = 3;
  localparam logic [3:0] LINK_IDLE = 4'ha;

  typedef struct packed {
    logic start;
    logic [2:0] channel_sel;
    logic polarity_select;
    logic input_config_select;
    logic [1:0] mode_sel;
  } sac_ctrl_word_type;

  typedef struct packed {
    logic hw_pd;
    logic soft_pd;
    logic done;
    logic running;
    sac_ctrl_word_type cw;
  } sac_status_type;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_PDOWN} sac_state_type;
endpackage

// ---- rtl/sac_serial_ctrl.sv ----
// Serial control and conversion sequencer of the SAR converter.
`timescale 1ns/1ns
module sac_serial_ctrl
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic select_low_i,
  input wire logic sdi_i,
  input wire logic hw_powerdown_low_i,
  input wire logic comparator_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic conversion_done_strobe_o,
  output logic track_o,
  output logic [9:0] dac_code_o,
  output logic [2:0] channel_sel_o,
  output logic polarity_select_o,
  output logic input_config_select_o,
  output logic power_down_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  logic [3:0] pins;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] filt;
  logic [3:0] filt_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;
  logic hw_pd;
  logic sdi_v;
  logic rx_active;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sr;
  logic byte_done;
  logic start_seen;
  sac_ctrl_word_type cw;
  sac_state_type state;
  logic [3:0] step;
  logic [3:0] bit_idx;
  logic [9:0] code;
  logic [9:0] result;
  logic [9:0] next_result;
  logic int_mode;
  logic soft_pd_mode;
  logic step_evt;
  logic conv_end;
  logic out_bit;
  logic [4:0] osc_div;
  logic [4:0] osc_cnt;
  logic osc_tick;
  logic [9:0] rd_sr;
  logic [3:0] rd_cnt;
  logic [31:0] rd_mux;
  sac_status_type status;

  assign pins = {hw_powerdown_low_i, sdi_i, select_low_i, sclk_i};

  // A level change is taken only once the second and third stages agree.
  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync1[g] <= LINK_IDLE[g];
          sync2[g] <= LINK_IDLE[g];
          sync3[g] <= LINK_IDLE[g];
          filt[g] <= LINK_IDLE[g];
          filt_d[g] <= LINK_IDLE[g];
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            filt[g] <= sync3[g];
          end
          filt_d[g] <= filt[g];
        end
      end
    end
  endgenerate

  assign sclk_rise = filt[LNK_SCLK] & ~filt_d[LNK_SCLK];
  assign sclk_fall = ~filt[LNK_SCLK] & filt_d[LNK_SCLK];
  assign cs_act = ~filt[LNK_CS];
  assign hw_pd = ~filt[LNK_HWPD];
  assign sdi_v = filt[LNK_SDI];

  // RULE_07 start bit detect
  assign start_seen = sclk_rise & ~rx_active & sdi_v & cs_act & ~hw_pd;
  // RULE_03 RULE_17 RULE_18 eighth fall
  assign byte_done = sclk_fall & rx_active & (rx_cnt == BYTE_BITS)
                     & cs_act & ~hw_pd;

  // RULE_22 sample on rising
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_active <= 1'b0;
      rx_cnt <= 4'h0;
      rx_sr <= 8'h00;
    end else if (hw_pd || !cs_act) begin
      rx_active <= 1'b0;
      rx_cnt <= 4'h0;
    end else if (byte_done) begin
      rx_active <= 1'b0;
      rx_cnt <= 4'h0;
    end else if (sclk_rise && rx_cnt != BYTE_BITS) begin
      if (rx_active) begin
        rx_sr <= {rx_sr[6:0], sdi_v};
        rx_cnt <= rx_cnt + 4'h1;
      end else if (sdi_v) begin
        rx_active <= 1'b1;
        rx_sr <= 8'h01;
        rx_cnt <= 4'h1;
      end
    end
  end

  // RULE_08 latch control fields
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cw <= '0;
    end else if (byte_done) begin
      cw <= sac_ctrl_word_type'(rx_sr);
    end
  end

  assign channel_sel_o = cw.channel_sel;
  // RULE_10 input configuration
  assign input_config_select_o = cw.input_config_select;
  // RULE_09 output coding
  assign polarity_select_o = cw.polarity_select;

  // RULE_11 mode decode
  assign int_mode = (cw.mode_sel == MODE_INT_CLK);
  assign soft_pd_mode = (cw.mode_sel == MODE_FULL_PD)
                        | (cw.mode_sel == MODE_FAST_PD);

  // RULE_02 track window
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      track_o <= 1'b0;
    end else begin
      track_o <= rx_active & (rx_cnt >= TRACK_FROM_BIT) & cs_act & ~hw_pd;
    end
  end

  // The oscillator period is software tunable; zero wraps to 32 cycles.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_cnt <= 5'h00;
    end else if (state != ST_CONV || !int_mode || byte_done || osc_tick) begin
      osc_cnt <= osc_div - 5'h01;
    end else begin
      osc_cnt <= osc_cnt - 5'h01;
    end
  end

  assign osc_tick = (osc_cnt == 5'h00);

  // RULE_06 RULE_12 conversion clock source
  assign step_evt = (state == ST_CONV) & (int_mode ? osc_tick : sclk_fall);
  // RULE_04 twelve plus one
  assign conv_end = step_evt & (step == STEP_LAST) & ~hw_pd & ~byte_done;
  assign bit_idx = 4'ha - step;
  // RULE_09 bipolar flips MSB
  assign out_bit = (bit_idx == 4'h9) ? comparator_i ^ ~cw.polarity_select
                                     : comparator_i;
  assign next_result = {code[9] ^ ~cw.polarity_select, code[8:0]};

  // RULE_21 shutdown aborts
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      step <= 4'h0;
      code <= 10'h000;
      result <= 10'h000;
    end else if (hw_pd) begin
      state <= ST_IDLE;
      step <= 4'h0;
    end else if (byte_done) begin
      state <= ST_CONV;
      step <= 4'h0;
      code <= 10'h000;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_PDOWN: begin
          // RULE_20 wake on start
          if (start_seen) begin
            state <= ST_IDLE;
          end
        end
        ST_CONV: begin
          // RULE_15 ignores select
          if (step_evt) begin
            step <= step + 4'h1;
            if (step == 4'h0) begin
              code <= SAR_FIRST_TRIAL;
            end else if (step <= STEP_LAST_BIT) begin
              code[bit_idx] <= comparator_i;
              if (bit_idx != 4'h0) begin
                code[bit_idx - 4'h1] <= 1'b1;
              end
            end
            if (step == STEP_LAST) begin
              result <= next_result;
              state <= soft_pd_mode ? ST_PDOWN : ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign dac_code_o = code;

  // Output bit and internal-mode readout; readout keeps shifting when
  // a new control byte arrives, so read and restart can interleave.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      rd_sr <= 10'h000;
      rd_cnt <= 4'h0;
    end else begin
      // RULE_16 release when deselected
      sdo_oe_o <= cs_act;
      if (conv_end && int_mode) begin
        rd_sr <= next_result;
        rd_cnt <= RESULT_BITS;
      end else if (sclk_fall && cs_act) begin
        // RULE_22 RULE_23 drive on falling
        if (state == ST_CONV && !int_mode && step >= STEP_FIRST_BIT
            && step <= STEP_LAST_BIT) begin
          sdo_o <= out_bit;
        end else if (rd_cnt != 4'h0) begin
          // RULE_14 interleaved readout
          sdo_o <= rd_sr[9];
          rd_sr <= {rd_sr[8:0], 1'b0};
          rd_cnt <= rd_cnt - 4'h1;
        end else begin
          // RULE_05 zero fill
          sdo_o <= 1'b0;
        end
      end
    end
  end

  // RULE_13 done strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conversion_done_strobe_o <= 1'b0;
    end else if (byte_done || hw_pd) begin
      conversion_done_strobe_o <= 1'b0;
    end else if (conv_end && int_mode) begin
      conversion_done_strobe_o <= 1'b1;
    end
  end

  // RULE_21 power down output
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_down_o <= 1'b0;
    end else begin
      power_down_o <= hw_pd | (state == ST_PDOWN);
    end
  end

  assign status = '{hw_pd: hw_pd, soft_pd: state == ST_PDOWN,
                    done: conversion_done_strobe_o,
                    running: state == ST_CONV, cw: cw};

  always_comb begin
    case (avs_address_i)
      REG_CTRL: rd_mux = {27'h0, osc_div};
      REG_STATUS: rd_mux = {20'h0, status};
      REG_RESULT: rd_mux = {22'h0, result};
      default: rd_mux = 32'h0;
    endcase
  end

  // Every access is answered one cycle after it is seen.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      avs_waitrequest_o <= 1'b1;
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_div <= CTRL_RESET;
    end else if (avs_write_i && !avs_waitrequest_o
                 && avs_address_i == REG_CTRL) begin
      osc_div <= avs_writedata_i[4:0];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_SDO_RELEASE: assert property ( // RULE_16
    !cs_act |=> !sdo_oe_o)
    else $error("serial output driven while deselected");

  AST_TRACK_WINDOW: assert property ( // RULE_02
    track_o |-> $past(rx_active) && $past(rx_cnt) >= TRACK_FROM_BIT)
    else $error("tracking outside the control byte tail");

  AST_CONV_START: assert property ( // RULE_03
    byte_done |=> state == ST_CONV && step == 4'h0)
    else $error("conversion did not start after eighth bit");

  AST_STEP_BOUND: assert property ( // RULE_04
    state == ST_CONV |-> step <= STEP_LAST)
    else $error("conversion ran past its last step");

  AST_CONV_FINISH: assert property ( // RULE_04
    conv_end |=> state != ST_CONV && result == $past(next_result))
    else $error("conversion did not finish on its last step");

  AST_ZERO_FILL: assert property ( // RULE_05
    sclk_fall && cs_act && state != ST_CONV && rd_cnt == 4'h0
    && !(conv_end && int_mode) |=> !sdo_o)
    else $error("trailing clocks did not shift zeros");

  AST_FIELDS: assert property ( // RULE_08
    byte_done |=> channel_sel_o == $past(rx_sr[6:4])
    && polarity_select_o == $past(rx_sr[3])
    && input_config_select_o == $past(rx_sr[2]))
    else $error("control fields not taken from the byte");

  AST_INT_STEP: assert property ( // RULE_12
    state == ST_CONV && int_mode && !hw_pd && !byte_done
    |-> ##[1:40] (step != $past(step) || state != ST_CONV))
    else $error("internal conversion stalled");

  AST_STROBE_LOW: assert property ( // RULE_13
    byte_done |=> !conversion_done_strobe_o)
    else $error("done strobe high while converting");

  AST_STROBE_HIGH: assert property ( // RULE_13
    conv_end && int_mode |=> conversion_done_strobe_o && rd_cnt == 4'ha)
    else $error("done strobe not raised at the end");

  AST_WAKE: assert property ( // RULE_20
    state == ST_PDOWN && start_seen && !hw_pd |=> ##1 !power_down_o)
    else $error("start bit did not wake the device");

  AST_HW_PD: assert property ( // RULE_21
    hw_pd |=> state != ST_CONV && power_down_o)
    else $error("shutdown pin did not power down");

  COV_EXT_CONV: cover property (conv_end && !int_mode);
  COV_INT_CONV: cover property (conv_end && int_mode);
  COV_INT_NO_SELECT: cover property (state == ST_CONV && int_mode && !cs_act);
  COV_WAKE: cover property (state == ST_PDOWN && start_seen);
  COV_BUS_WRITE: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

// ---- sim/sac_host_model.sv ----
// Host-side serial master that frames control bytes and reads results.
`timescale 1ns/1ns
module sac_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic select_low_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b0;
    select_low_o = 1'b1;
    sdi_o = 1'b0;
  end

  task automatic frame(input logic [63:0] mosi, input int n,
                       output logic [63:0] miso);
    miso = '0;
    @(posedge clk_i);
    select_low_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int j = 0; j < n; j++) begin
      @(posedge clk_i);
      sclk_o <= 1'b0;
      sdi_o <= mosi[n-1-j];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      // Output is taken late in the high phase, since it settles slowly.
      @(negedge clk_i);
      miso[j] = sdo_i;
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge clk_i);
    select_low_o <= 1'b1;
    // Select must stay high long enough for the device to see a gap.
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the SAR converter serial control block.
`timescale 1ns/1ns
module tb;
  import sac_pkg::*;
  logic clk_i;
  logic resetn_i;
  logic hwpd_low;
  logic [3:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic sclk, select_low, sdi, sdo, sdo_oe, sdo_last, sdo_line, strobe;
  logic [9:0] dac_code;
  logic [9:0] ain;
  logic [2:0] chan;
  logic pol, cfg, pd, track;
  logic [31:0] d;
  logic [63:0] m;
  int errors = 0;
  int cmp_count = 0;
  int track_cnt = 0;

  // A released output line shows the inverse of its last driven bit.
  assign sdo_line = sdo_oe ? sdo : ~sdo_last;
  always @(posedge clk_i) if (sdo_oe) sdo_last <= sdo;
  always @(posedge clk_i) if (track === 1'b1) track_cnt++;

  sac_serial_ctrl u_sac_serial_ctrl (
    .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
    .select_low_i(select_low), .sdi_i(sdi), .hw_powerdown_low_i(hwpd_low),
    .comparator_i(ain >= dac_code), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .conversion_done_strobe_o(strobe), .track_o(track),
    .dac_code_o(dac_code),
    .channel_sel_o(chan), .polarity_select_o(pol),
    .input_config_select_o(cfg), .power_down_o(pd),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

  sac_host_model u_sac_host_model (.clk_i(clk_i), .sdo_i(sdo_line),
    .sclk_o(sclk), .select_low_o(select_low), .sdi_o(sdi));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r & mask, exp);
  endtask

  function automatic logic [9:0] rbits(input logic [63:0] v, input int j0);
    logic [9:0] r;
    for (int k = 0; k < 10; k++) r[9-k] = v[j0+k];
    return r;
  endfunction

  task automatic t_regs();
    rd_chk(REG_CTRL, 32'h1f, 32'hf);
    bus(1'b1, REG_CTRL, 32'h2, d);
    rd_chk(REG_CTRL, 32'h1f, 32'h2);
    bus(1'b1, 4'hc, 32'hffff_ffff, d);
    rd_chk(4'hc, 32'hffff_ffff, 32'h0);
  endtask

  task automatic t_ext24(input logic [7:0] c, input logic [9:0] a);
    logic [9:0] res;
    int t0;
    res = c[3] ? a : a ^ 10'h200;
    t0 = track_cnt;
    ain <= a;
    u_sac_host_model.frame({40'h0, c, 16'h0}, 24, m);
    // Tracking spans 2.5 link clocks of eight system clocks each.
    chk(32'(track_cnt - t0), 32'd20);
    chk(32'(rbits(m, 10)), 32'(res));
    chk(32'({m[23:20], m[9]}), 32'h0);
    chk(32'({chan, pol, cfg}), 32'(c[6:2]));
    repeat (8) @(posedge clk_i);
    chk(32'({sdo_oe, strobe}), 32'h0);
    rd_chk(REG_STATUS, 32'hfff, 32'(c));
    rd_chk(REG_RESULT, 32'h3ff, 32'(res));
  endtask

  // Second byte rides on the tail of the first result.
  task automatic t_interleave(input int gap);
    ain <= 10'h1c7;
    u_sac_host_model.frame((64'hcf << (gap + 24)) | (64'ha7 << 16),
                           gap + 32, m);
    chk(32'(rbits(m, 10)), 32'h1c7);
    chk(32'(rbits(m, gap + 18)), 32'h3c7);
  endtask

  task automatic t_internal();
    int k;
    k = 0;
    ain <= 10'h0e3;
    u_sac_host_model.frame(64'hee, 8, m);
    chk(32'({strobe, sdo_oe}), 32'h0);
    while (strobe !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(strobe), 32'h1);
    u_sac_host_model.frame(64'h0, 16, m);
    chk(32'(rbits(m, 1)), 32'h0e3);
  endtask

  task automatic t_power();
    ain <= 10'h300;
    for (int md = 0; md < 2; md++) begin
      u_sac_host_model.frame({40'h0, 8'hcc | 8'(md), 16'h0}, 24, m);
      chk(32'(pd), 32'h1);
    end
    u_sac_host_model.frame({40'h0, 8'hcf, 16'h0}, 24, m);
    chk(32'({pd, rbits(m, 10)}), 32'h300);
    hwpd_low <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'(pd), 32'h1);
    rd_chk(REG_STATUS, 32'h800, 32'h800);
    hwpd_low <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(pd), 32'h0);
  endtask

  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The whole run needs under 10000 cycles; this margin catches a hang.
  initial begin
    repeat (50000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    resetn_i = 1'b0;
    hwpd_low = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    ain = 10'h0;
    sdo_last = 1'b0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_ext24(8'hdf, 10'h2a5);
    t_ext24(8'h93, 10'h15a);
    t_interleave(8);
    t_interleave(5);
    t_internal();
    t_power();
    give_verdict();
  end
endmodule
